// File: logic/btc_top.sv
// What this block does
// - Code 1010 in bits 7-4 disables watchdog
// - Bits 3-2 pick timer clock /4096../16
// - Writing one to bit 1 clears counter
// - Counter clear bit returns to zero itself
// - Writing one to bit 0 clears dividers
// - Divider clear bit never reads as one
// - All dividers run from main clock
// - Bits 4-3 pick CPU clock /16../1
// - Reset selects slowest CPU clock, /16
// - Bit 7 set blocks interrupt wake-up
// - Unused clock bits do not affect clocking
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
`include "btc_consts.svh"
module btc_top #(
  parameter int ADR_W = 12
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  cyc_i,
  input  wire logic                  stb_i,
  input  wire logic                  we_i,
  input  wire logic [ADR_W-1:0]      adr_i,
  input  wire logic [3:0]            sel_i,
  input  wire logic [31:0]           dat_i,
  output logic      [31:0]           dat_o,
  output logic                       ack_o,
  input  wire logic                  irq_pending_i,
  output logic                       wake_o,
  output logic                       wdt_reset_o,
  output logic                       cpu_tick_o,
  output btc_pkg::btc_cpu_sel_e      cpu_clk_sel_o
);
  import btc_pkg::*;

  logic [3:0]                  wdt_code_r;
  btc_bt_sel_e                 bt_sel_r;
  logic                        wake_dis_r;
  btc_cpu_sel_e                cpu_sel_r;
  logic                        ack_r;
  logic [31:0]                 dat_r;
  logic                        cpu_tick_r;
  logic                        cpu_tick_nxt;
  logic                        wake_r;
  logic                        wdt_rst_r;
  logic                        bt_tick;
  logic                        wdt_en;
  logic                        wr_commit;
  logic                        hit_wdt;
  logic                        hit_cpu;
  logic                        hit_cnt;
  logic                        cnt_clr;
  logic                        div_clr;
  logic                        bt_ovf;
  btc_byte_t                   rd_byte;
  logic [`BTC_IDX_W-1:0]       idx;
  logic [`BTC_BT_PRE_W-1:0]    bt_pre;
  logic [`BTC_CPU_PRE_W-1:0]   cpu_pre;
  logic [`BTC_CNT_W-1:0]       bt_cnt;

  // Wishbone slave: ack one cycle after the request, dropped the cycle after.
  // Writes take effect on the edge where the master sees ack.
  assign idx       = adr_i[`BTC_IDX_W+1:2];
  assign hit_wdt   = (idx == `BTC_IDX_WDT);
  assign hit_cpu   = (idx == `BTC_IDX_CPU);
  assign hit_cnt   = (idx == `BTC_IDX_CNT);
  assign wr_commit = cyc_i && stb_i && we_i && ack_r && sel_i[0];
  assign cnt_clr   = wr_commit && hit_wdt && dat_i[`BTC_CNT_CLR_BIT];
  assign div_clr   = wr_commit && hit_wdt && dat_i[`BTC_DIV_CLR_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= cyc_i && stb_i && !ack_r;
    end
  end

  // Unmapped indices answer with ack and zero data so the master never hangs.
  always_comb begin
    rd_byte = 8'h00;
    if (hit_wdt) begin
      // The two clear strobes are not stored, so they always read zero.
      rd_byte[`BTC_WDT_CODE_MSB:`BTC_WDT_CODE_LSB] = wdt_code_r;
      rd_byte[`BTC_BT_SEL_MSB:`BTC_BT_SEL_LSB]     = bt_sel_r;
    end else if (hit_cpu) begin
      rd_byte[`BTC_WAKE_DIS_BIT]                   = wake_dis_r;
      rd_byte[`BTC_CPU_SEL_MSB:`BTC_CPU_SEL_LSB]   = cpu_sel_r;
    end else if (hit_cnt) begin
      rd_byte = bt_cnt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= 32'h0000_0000;
    end else if (cyc_i && stb_i && !we_i && !ack_r) begin
      dat_r <= {24'h00_0000, rd_byte};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdt_code_r <= `BTC_WDT_CODE_RST;
      bt_sel_r   <= btc_bt_sel_e'(`BTC_BT_SEL_RST);
    end else if (wr_commit && hit_wdt) begin
      wdt_code_r <= dat_i[`BTC_WDT_CODE_MSB:`BTC_WDT_CODE_LSB];
      bt_sel_r   <= btc_bt_sel_e'(dat_i[`BTC_BT_SEL_MSB:`BTC_BT_SEL_LSB]);
    end
  end

  // Only bits 7 and 4-3 are stored; writes to the other bits are dropped.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_dis_r <= `BTC_WAKE_DIS_RST;
      cpu_sel_r  <= btc_cpu_sel_e'(`BTC_CPU_SEL_RST);
    end else if (wr_commit && hit_cpu) begin
      wake_dis_r <= dat_i[`BTC_WAKE_DIS_BIT];
      cpu_sel_r  <= btc_cpu_sel_e'(dat_i[`BTC_CPU_SEL_MSB:`BTC_CPU_SEL_LSB]);
    end
  end

  // Both dividers count the main clock directly; there is no other source.
  btc_prescaler #(
    .W (`BTC_BT_PRE_W)
  ) u_bt_pre (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .clr_i (div_clr),
    .cnt_o (bt_pre)
  );

  btc_prescaler #(
    .W (`BTC_CPU_PRE_W)
  ) u_cpu_pre (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .clr_i (div_clr),
    .cnt_o (cpu_pre)
  );

  always_comb begin
    case (bt_sel_r)
      BTC_BT_DIV4096: bt_tick = &bt_pre;
      BTC_BT_DIV1024: bt_tick = &bt_pre[`BTC_BT_TAP_1024-1:0];
      BTC_BT_DIV128:  bt_tick = &bt_pre[`BTC_BT_TAP_128-1:0];
      default:        bt_tick = &bt_pre[`BTC_BT_TAP_16-1:0];
    endcase
  end

  always_comb begin
    case (cpu_sel_r)
      BTC_CPU_DIV16: cpu_tick_nxt = &cpu_pre;
      BTC_CPU_DIV8:  cpu_tick_nxt = &cpu_pre[`BTC_CPU_TAP_8-1:0];
      BTC_CPU_DIV2:  cpu_tick_nxt = &cpu_pre[`BTC_CPU_TAP_2-1:0];
      default:       cpu_tick_nxt = 1'b1;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpu_tick_r <= 1'b0;
    end else begin
      cpu_tick_r <= cpu_tick_nxt;
    end
  end

  btc_basic_counter #(
    .W (`BTC_CNT_W)
  ) u_bt_cnt (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .clr_i (cnt_clr),
    .inc_i (bt_tick),
    .cnt_o (bt_cnt),
    .ovf_o (bt_ovf)
  );

  assign wdt_en = (wdt_code_r != `BTC_WDT_OFF_CODE);

  // The reset pulse is registered so that it is glitch free at the reset tree.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdt_rst_r <= 1'b0;
    end else begin
      wdt_rst_r <= bt_ovf && wdt_en;
    end
  end

  // Pending interrupt comes from logic on this clock, so it is not synchronised.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_r <= 1'b0;
    end else begin
      wake_r <= irq_pending_i && !wake_dis_r;
    end
  end

  assign ack_o         = ack_r;
  assign dat_o         = dat_r;
  assign wake_o        = wake_r;
  assign wdt_reset_o   = wdt_rst_r;
  assign cpu_tick_o    = cpu_tick_r;
  assign cpu_clk_sel_o = cpu_sel_r;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  AST_WDT_OFF: assert property (
    bt_ovf && (wdt_code_r == `BTC_WDT_OFF_CODE) |=> !wdt_reset_o
  ) else $error("Watchdog reset fired while disabled.");

  AST_WDT_FIRE: assert property (
    bt_ovf && (wdt_code_r != `BTC_WDT_OFF_CODE) |=> wdt_reset_o
  ) else $error("Watchdog overflow did not raise reset.");

  AST_OVF_CAUSE: assert property (
    wdt_reset_o |-> $past(bt_ovf) && $past(bt_cnt, 2) == 8'hFF
  ) else $error("Watchdog reset without a counter wrap.");

  AST_BT_TAP: assert property (
    bt_tick && (bt_sel_r == BTC_BT_DIV128) |-> bt_pre[6:0] == 7'h7F && $past(bt_pre[6:0]) == 7'h7E
  ) else $error("Basic timer tick off its divide tap.");

  AST_CNT_CLR: assert property (
    cnt_clr |=> bt_cnt == 8'h00 && !bt_ovf
  ) else $error("Counter clear write did not zero the counter.");

  AST_STROBE_READ: assert property (
    ack_o && !we_i && hit_wdt |-> dat_o[1:0] == 2'h0
  ) else $error("Clear strobe bits read back as set.");

  AST_DIV_CLR: assert property (
    div_clr |=> bt_pre == 12'h000 && cpu_pre == 4'h0 ##1 bt_pre == 12'h001
  ) else $error("Divider clear write did not zero both dividers.");

  AST_CPU_FULL: assert property (
    cpu_sel_r == BTC_CPU_DIV1 |=> cpu_tick_o
  ) else $error("Undivided CPU clock missed a tick.");

  AST_CPU_DIV2: assert property (
    cpu_sel_r == BTC_CPU_DIV2 && $past(cpu_sel_r) == BTC_CPU_DIV2 && cpu_tick_o && !div_clr |=> !cpu_tick_o
  ) else $error("CPU divide by two ticked twice in a row.");

  AST_RESET_SLOW: assert property (
    $fell(rst_i) |-> cpu_clk_sel_o == BTC_CPU_DIV16 && !wdt_reset_o
  ) else $error("CPU clock not at slowest setting after reset.");

  AST_WAKE: assert property (
    irq_pending_i |=> wake_o == !$past(wake_dis_r)
  ) else $error("Interrupt wake-up gating wrong.");

  AST_UNUSED_BITS: assert property (
    ack_o && !we_i && hit_cpu |-> dat_o[6:5] == 2'h0 && dat_o[2:0] == 3'h0
  ) else $error("Unused clock control bits read nonzero.");

  AST_UNUSED_WRITE: assert property (
    wr_commit && hit_cpu |=> cpu_sel_r == btc_cpu_sel_e'($past(dat_i[4:3]))
  ) else $error("CPU clock select not taken from bits 4-3.");

  AST_ACK_ONE: assert property (
    ack_o |=> !ack_o
  ) else $error("Acknowledge held longer than one cycle.");

  // A request that is not yet answered must be answered on the very next edge.
  AST_ACK_RISE: assert property (
    cyc_i && stb_i && !ack_o |=> ack_o
  ) else $error("Request was not acknowledged after one cycle.");

  AST_RD_HIGH_ZERO: assert property (
    ack_o && !we_i |-> dat_o[31:8] == 24'h00_0000
  ) else $error("Read data above the low byte is nonzero.");

  AST_RD_CPU: assert property (
    ack_o && !we_i && hit_cpu |-> dat_o[7:0] == {wake_dis_r, 2'h0, cpu_sel_r, 3'h0}
  ) else $error("Clock control read does not match stored fields.");

  AST_WAKE_BLOCK: assert property (
    wake_dis_r |=> !wake_o
  ) else $error("Wake-up raised while interrupt wake-up is blocked.");

  AST_CNT_STEP: assert property (
    !cnt_clr && bt_tick |=> bt_cnt == $past(bt_cnt) + 8'h01
  ) else $error("Basic timer counter did not step on its tick.");

  AST_CNT_HOLD: assert property (
    !cnt_clr && !bt_tick |=> $stable(bt_cnt)
  ) else $error("Basic timer counter moved without a tick.");

  AST_WDT_PULSE: assert property (
    wdt_reset_o |=> !wdt_reset_o
  ) else $error("Watchdog reset request longer than one cycle.");

  AST_CPU_DIV16: assert property (
    cpu_tick_o && $past(cpu_sel_r) == BTC_CPU_DIV16 |-> $past(cpu_pre) == 4'hF
  ) else $error("CPU divide by sixteen ticked off its tap.");

  // Control fields may only move on a committed write to their own register.
  AST_WDT_HOLD: assert property (
    !(wr_commit && hit_wdt) |=> $stable(wdt_code_r) && $stable(bt_sel_r)
  ) else $error("Watchdog control fields changed without a write.");

  COV_WDT_RESET: cover property (wdt_reset_o);
  COV_WDT_DISABLED_OVF: cover property (bt_ovf && !wdt_en);
  COV_CNT_CLEARED: cover property (cnt_clr ##1 bt_tick);
  COV_WAKE_BLOCKED: cover property (irq_pending_i && wake_dis_r);

endmodule // btc_top
`default_nettype wire

// File: shared/btc_consts.svh
`ifndef BTC_CONSTS_SVH
`define BTC_CONSTS_SVH

// Register indices; the byte address on the bus is four times the index.
`define BTC_IDX_W          10
`define BTC_IDX_WDT        10'h0D3
`define BTC_IDX_CPU        10'h0D4
`define BTC_IDX_CNT        10'h0FD

// Watchdog and basic timer control fields.
`define BTC_WDT_CODE_MSB   7
`define BTC_WDT_CODE_LSB   4
`define BTC_BT_SEL_MSB     3
`define BTC_BT_SEL_LSB     2
`define BTC_CNT_CLR_BIT    1
`define BTC_DIV_CLR_BIT    0
`define BTC_WDT_OFF_CODE   4'hA
`define BTC_WDT_CODE_RST   4'h0
`define BTC_BT_SEL_RST     2'h0

// CPU clock control fields.
`define BTC_WAKE_DIS_BIT   7
`define BTC_CPU_SEL_MSB    4
`define BTC_CPU_SEL_LSB    3
`define BTC_WAKE_DIS_RST   1'h0
`define BTC_CPU_SEL_RST    2'h0

// Divider widths and tap widths (a tap of n bits divides by two to the n).
`define BTC_BT_PRE_W       12
`define BTC_BT_TAP_1024    10
`define BTC_BT_TAP_128     7
`define BTC_BT_TAP_16      4
`define BTC_CPU_PRE_W      4
`define BTC_CPU_TAP_8      3
`define BTC_CPU_TAP_2      1
`define BTC_CNT_W          8

`endif

// File: shared/btc_pkg.sv
`default_nettype none
package btc_pkg;

  typedef enum logic [1:0] {
    BTC_BT_DIV4096 = 2'b00,
    BTC_BT_DIV1024 = 2'b01,
    BTC_BT_DIV128  = 2'b10,
    BTC_BT_DIV16   = 2'b11
  } btc_bt_sel_e;

  typedef enum logic [1:0] {
    BTC_CPU_DIV16 = 2'b00,
    BTC_CPU_DIV8  = 2'b01,
    BTC_CPU_DIV2  = 2'b10,
    BTC_CPU_DIV1  = 2'b11
  } btc_cpu_sel_e;

  typedef logic [7:0] btc_byte_t;

endpackage
`default_nettype wire

// File: logic/btc_prescaler.sv
`timescale 1ns/1ns
`default_nettype none
// Free-running divider of the main clock; taps are read by the parent.
module btc_prescaler #(
  parameter int W = 12
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         clr_i,
  output logic [W-1:0]      cnt_o
);
  always_ff @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      cnt_o <= '0;
    end else begin
      cnt_o <= cnt_o + W'(1);
    end
  end
endmodule // btc_prescaler
`default_nettype wire

// File: logic/btc_basic_counter.sv
`timescale 1ns/1ns
`default_nettype none
// Up-counter with clear priority; overflow is a one-cycle pulse on the wrap.
module btc_basic_counter #(
  parameter int W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         clr_i,
  input  wire logic         inc_i,
  output logic [W-1:0]      cnt_o,
  output logic              ovf_o
);
  always_ff @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      cnt_o <= '0;
    end else if (inc_i) begin
      cnt_o <= cnt_o + W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      ovf_o <= 1'b0;
    end else begin
      ovf_o <= inc_i && (&cnt_o);
    end
  end
endmodule // btc_basic_counter
`default_nettype wire

// File: dv/btc_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module btc_top_tb;
  import btc_pkg::*;

  localparam logic [11:0] ADR_WDT = 12'h34C;
  localparam logic [11:0] ADR_CPU = 12'h350;
  localparam logic [11:0] ADR_CNT = 12'h3F4;
  localparam logic [11:0] ADR_BAD = 12'h100;

  logic         clk;
  logic         rst;
  logic         cyc;
  logic         stb;
  logic         we;
  logic         irq_pending;
  logic         ack;
  logic         wake;
  logic         wdt_reset;
  logic         cpu_tick;
  logic [11:0]  adr;
  logic [3:0]   sel;
  logic [31:0]  dat_w;
  logic [31:0]  dat_r;
  logic [31:0]  rd;
  btc_cpu_sel_e cpu_sel;
  int           failures;
  int           checks_done;
  int           n;
  int           exp_ticks [4] = '{2, 4, 16, 32};
  int           exp_cnt   [4] = '{0, 3, 31, 250};

  initial clk = 1'b0;
  always #10 clk = ~clk;

  btc_top #(.ADR_W(12)) u_btc_top (
    .clk_i         (clk),
    .rst_i         (rst),
    .cyc_i         (cyc),
    .stb_i         (stb),
    .we_i          (we),
    .adr_i         (adr),
    .sel_i         (sel),
    .dat_i         (dat_w),
    .dat_o         (dat_r),
    .ack_o         (ack),
    .irq_pending_i (irq_pending),
    .wake_o        (wake),
    .wdt_reset_o   (wdt_reset),
    .cpu_tick_o    (cpu_tick),
    .cpu_clk_sel_o (cpu_sel)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (failures == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Classic single cycle; ack and read data are taken at the edge that samples ack high.
  task automatic xfer(input logic [11:0] a, input logic w, input logic [7:0] d, input logic [3:0] s);
    int k;
    @(posedge clk);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= a;
    sel   <= s;
    dat_w <= {24'h000000, d};
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 100);
    if (k >= 100) begin
      failures++;
    end
    rd = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 8'h00, 4'hF);
    check(rd, exp);
  endtask

  task automatic count_ticks();
    n = 0;
    repeat (32) begin
      @(posedge clk);
      if (cpu_tick === 1'b1) begin
        n++;
      end
    end
  endtask

  // Clears counter and dividers with the given code, then waits for the reset request.
  task automatic wdt_run(input logic [3:0] code, input logic fire);
    xfer(ADR_WDT, 1'b1, {code, 4'hF}, 4'hF);
    n = 0;
    while (wdt_reset !== 1'b1 && n < 4200) begin
      @(posedge clk);
      n++;
    end
    if (fire) begin
      check(n, 32'h1002);
    end else begin
      check(n, 32'h1068);
    end
  endtask

  initial begin
    rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0;
    adr = 12'h000; sel = 4'h0; dat_w = 32'h0; irq_pending = 1'b0;
    failures = 0;
    checks_done = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check({30'h0, cpu_sel}, 32'h0);
    rd_chk(ADR_WDT, 32'h0);
    rd_chk(ADR_CPU, 32'h0);
    rd_chk(ADR_CNT, 32'h0);
    xfer(ADR_CPU, 1'b1, 8'hFF, 4'hF);
    rd_chk(ADR_CPU, 32'h98);
    check({30'h0, cpu_sel}, 32'h3);
    xfer(ADR_CPU, 1'b1, 8'h67, 4'hF);
    rd_chk(ADR_CPU, 32'h0);
    check({30'h0, cpu_sel}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      xfer(ADR_CPU, 1'b1, {3'h0, i[1:0], 3'h0}, 4'hF);
      repeat (3) @(posedge clk);
      check({30'h0, cpu_sel}, i);
      count_ticks();
      check(n, exp_ticks[i]);
    end
    // A write without the low byte lane must leave the register alone.
    xfer(ADR_CPU, 1'b1, 8'h10, 4'hE);
    rd_chk(ADR_CPU, 32'h18);
    xfer(ADR_BAD, 1'b1, 8'h5A, 4'hF);
    rd_chk(ADR_BAD, 32'h0);
    xfer(ADR_CPU, 1'b1, 8'h00, 4'hF);
    irq_pending <= 1'b1;
    repeat (3) @(posedge clk);
    check({31'h0, wake}, 32'h1);
    xfer(ADR_CPU, 1'b1, 8'h80, 4'hF);
    repeat (3) @(posedge clk);
    check({31'h0, wake}, 32'h0);
    irq_pending <= 1'b0;
    xfer(ADR_WDT, 1'b1, 8'hA7, 4'hF);
    rd_chk(ADR_WDT, 32'hA4);
    rd_chk(ADR_CNT, 32'h0);
    repeat (1100) @(posedge clk);
    xfer(ADR_WDT, 1'b1, 8'hA4, 4'hF);
    rd_chk(ADR_CNT, 32'h1);
    for (int s = 0; s < 4; s++) begin
      xfer(ADR_WDT, 1'b1, {4'hA, s[1:0], 2'b11}, 4'hF);
      repeat (4000) @(posedge clk);
      rd_chk(ADR_CNT, exp_cnt[s]);
    end
    wdt_run(4'h0, 1'b1);
    wdt_run(4'hB, 1'b1);
    wdt_run(4'h5, 1'b1);
    wdt_run(4'h2, 1'b1);
    wdt_run(4'hA, 1'b0);
    test_done();
  end

  // The whole sequence needs about forty thousand cycles; this leaves ample margin.
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    test_done();
  end

endmodule // btc_top_tb
`default_nettype wire
